// file: logic/gsp_pkg.sv
// Package: register map, reset values, frame layout and carrier types of the preset bank.
package gsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int GSP_ADDR_W = 15;
  localparam int GSP_CODE_W = 6;
  localparam int GSP_STEP_W = 5;
  localparam int GSP_TRIM_W = 4;

  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_PATH_CTRL = 15'h0100;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_ATT0_TX = 15'h0102;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_ATT0_IDLE = 15'h0103;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_MAN_FIRST = 15'h010a;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_MAN_SECOND = 15'h010b;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_LIN_CTRL = 15'h0110;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_TRIM1 = 15'h0111;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_TRIM2 = 15'h0112;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_TRIM3 = 15'h0113;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_ATT1 = 15'h0114;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_ATT2 = 15'h0115;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_ATT3 = 15'h0116;
  localparam logic [GSP_ADDR_W-1:0] GSP_OFS_LEVEL = 15'h0120;

  // Field positions.
  localparam int GSP_POS_MAN_EN = 7;
  localparam int GSP_POS_LIN_OFF1 = 0;
  localparam int GSP_POS_LEVEL = 0;
  localparam int GSP_POS_TRIM_SECOND = 4;

  // Reset values.
  localparam logic [GSP_CODE_W-1:0] GSP_RST_ATT0 = 6'h3f;
  localparam logic [GSP_CODE_W-1:0] GSP_RST_ATT1 = 6'h18;
  localparam logic [GSP_CODE_W-1:0] GSP_RST_ATT2 = 6'h30;
  localparam logic [GSP_CODE_W-1:0] GSP_RST_ATT3 = 6'h3f;
  localparam logic [GSP_STEP_W-1:0] GSP_RST_MAN = 5'h00;
  localparam logic [7:0] GSP_RST_TRIM = 8'h55;
  localparam logic GSP_RST_BIT = 1'b0;

  // Stage split: codes up to the boundary use only the second stage.
  localparam logic [GSP_CODE_W-1:0] GSP_CODE_BOUNDARY = 6'h20;
  localparam logic [GSP_STEP_W-1:0] GSP_STEP_FULL = 5'h1f;

  // Serial frame: read flag, 15-bit address, 8 data bits, MSB first.
  localparam logic [4:0] GSP_HDR_LAST = 5'h0f;
  localparam logic [4:0] GSP_FRAME_LAST = 5'h17;
  localparam logic [4:0] GSP_FRAME_BITS = 5'h18;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic sclk;
    logic csb_n;
    logic sdi;
    logic tx_en;
    logic [1:0] sel;
  } gsp_pins_type;

  typedef struct packed {
    logic [GSP_STEP_W-1:0] first_step_attenuator;
    logic [GSP_STEP_W-1:0] second_step_attenuator;
    logic [GSP_TRIM_W-1:0] second_amp_bias_trim;
    logic [GSP_TRIM_W-1:0] first_amp_bias_trim;
    logic first_amp_linearity_off;
  } gsp_amp_ctrl_type;

  typedef struct packed {
    logic manual_atten_enable;
    logic [GSP_CODE_W-1:0] att0_tx;
    logic [GSP_CODE_W-1:0] att0_idle;
    logic [GSP_STEP_W-1:0] man_first;
    logic [GSP_STEP_W-1:0] man_second;
    logic first_amp_linearity_off_state1;
    logic [7:0] bias_trim_state1;
    logic [7:0] bias_trim_state2;
    logic [7:0] bias_trim_state3;
    logic [GSP_CODE_W-1:0] atten_code_state1;
    logic [GSP_CODE_W-1:0] atten_code_state2;
    logic [GSP_CODE_W-1:0] atten_code_state3;
    logic readback_level_select;
  } gsp_regs_type;

  typedef struct packed {
    gsp_pins_type s1;
    gsp_pins_type s2;
    logic sclk_prev;
    logic [4:0] cnt;
    logic [23:0] sh;
    logic rd_active;
    logic [7:0] rd_sh;
    logic sdo;
    logic sdo_oe;
    gsp_regs_type regs;
    gsp_amp_ctrl_type amp;
  } gsp_state_type;

endpackage

// file: logic/gsp_preset_bank.sv
// Gain-state preset register bank with its serial register port and stage drive.
`timescale 1ns/1ps

//
// Behaviour
// - Transmit high, select 01: attenuator follows state-1 preset code bits [5:0].
// - Transmit high, select 10: attenuator follows state-2 preset code.
// - Transmit high, select 11: attenuator follows state-3 preset code.
// - Code 0 is no attenuation, code 63 is 31.00 dB, monotonic half-dB steps.
// - Codes 31 and 32 equal; up to there second stage only, then both stages.
// - State 1, 2, 3 attenuation presets reset to 0x18, 0x30, 0x3f.
// - Trim registers: second amp [7:4], first amp [3:0], each reset 0x5, writable.
// - Bias trims come from state 1, 2 or 3 register per select pins.
// - Linearity bit 0 set turns off first amp linearity currents in state 01 with transmit high.
// - Level bit 0 picks readback level, 0 is 1.8 V, 1 is 3.3 V.
// - Manual enable clear: presets drive stages; set with transmit high: two manual registers drive them.
// - State 00 uses one preset with transmit high, another with transmit low.
module gsp_preset_bank (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Serial register port pins.
  input wire logic spi_sclk_i,
  input wire logic spi_csb_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  output logic readback_level_select_o,
  // Gain state pins.
  input wire logic transmit_enable_pin_i,
  input wire logic [1:0] gain_state_select_pins_i,
  // Amplifier and attenuator controls.
  output gsp_pkg::gsp_amp_ctrl_type amp_ctrl_o
);
  import gsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  localparam gsp_regs_type REGS_RST = '{
    manual_atten_enable: GSP_RST_BIT,
    att0_tx: GSP_RST_ATT0,
    att0_idle: GSP_RST_ATT0,
    man_first: GSP_RST_MAN,
    man_second: GSP_RST_MAN,
    first_amp_linearity_off_state1: GSP_RST_BIT,
    bias_trim_state1: GSP_RST_TRIM,
    bias_trim_state2: GSP_RST_TRIM,
    bias_trim_state3: GSP_RST_TRIM,
    atten_code_state1: GSP_RST_ATT1,
    atten_code_state2: GSP_RST_ATT2,
    atten_code_state3: GSP_RST_ATT3,
    readback_level_select: GSP_RST_BIT
  };
  localparam gsp_amp_ctrl_type AMP_RST = '{
    first_step_attenuator: GSP_STEP_FULL,
    second_step_attenuator: GSP_STEP_FULL,
    second_amp_bias_trim: GSP_RST_TRIM[7:4],
    first_amp_bias_trim: GSP_RST_TRIM[3:0],
    first_amp_linearity_off: GSP_RST_BIT
  };
  localparam gsp_state_type STATE_RST = '{
    s1: '0,
    s2: '0,
    sclk_prev: 1'b0,
    cnt: 5'h00,
    sh: 24'h000000,
    rd_active: 1'b0,
    rd_sh: 8'h00,
    sdo: 1'b0,
    sdo_oe: 1'b0,
    regs: REGS_RST,
    amp: AMP_RST
  };

  gsp_state_type q;
  gsp_state_type d;
  logic rise;
  logic fall;
  logic [23:0] sh_next;
  logic [GSP_ADDR_W-1:0] rd_addr;
  logic [GSP_ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_val;
  logic [GSP_CODE_W-1:0] code;
  logic [7:0] trim;

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux; unmapped addresses and reserved bits read zero.
  always_comb begin
    rd_val = 8'h00;
    if (rd_addr == GSP_OFS_PATH_CTRL) begin
      rd_val[GSP_POS_MAN_EN] = q.regs.manual_atten_enable;
    end else if (rd_addr == GSP_OFS_ATT0_TX) begin
      rd_val = {2'b00, q.regs.att0_tx};
    end else if (rd_addr == GSP_OFS_ATT0_IDLE) begin
      rd_val = {2'b00, q.regs.att0_idle};
    end else if (rd_addr == GSP_OFS_MAN_FIRST) begin
      rd_val = {3'b000, q.regs.man_first};
    end else if (rd_addr == GSP_OFS_MAN_SECOND) begin
      rd_val = {3'b000, q.regs.man_second};
    end else if (rd_addr == GSP_OFS_LIN_CTRL) begin
      rd_val[GSP_POS_LIN_OFF1] = q.regs.first_amp_linearity_off_state1;
    end else if (rd_addr == GSP_OFS_TRIM1) begin
      rd_val = q.regs.bias_trim_state1;
    end else if (rd_addr == GSP_OFS_TRIM2) begin
      rd_val = q.regs.bias_trim_state2;
    end else if (rd_addr == GSP_OFS_TRIM3) begin
      rd_val = q.regs.bias_trim_state3;
    end else if (rd_addr == GSP_OFS_ATT1) begin
      rd_val = {2'b00, q.regs.atten_code_state1};
    end else if (rd_addr == GSP_OFS_ATT2) begin
      rd_val = {2'b00, q.regs.atten_code_state2};
    end else if (rd_addr == GSP_OFS_ATT3) begin
      rd_val = {2'b00, q.regs.atten_code_state3};
    end else if (rd_addr == GSP_OFS_LEVEL) begin
      rd_val[GSP_POS_LEVEL] = q.regs.readback_level_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    // Pins cross in through two flops; only the second stage feeds logic.
    d.s1 = '{spi_sclk_i, spi_csb_n_i, spi_sdi_i, transmit_enable_pin_i,
             gain_state_select_pins_i};
    d.s2 = q.s1;
    d.sclk_prev = q.s2.sclk;
    rise = q.s2.sclk & ~q.sclk_prev;
    fall = ~q.s2.sclk & q.sclk_prev;
    sh_next = {q.sh[22:0], q.s2.sdi};
    rd_addr = sh_next[GSP_ADDR_W-1:0];
    wr_addr = sh_next[22:8];
    wr_data = sh_next[7:0];

    // A frame is bounded by chip select; deselect aborts any partial frame.
    if (q.s2.csb_n) begin
      d.cnt = 5'h00;
      d.rd_active = 1'b0;
      d.sdo_oe = 1'b0;
    end else begin
      if (rise && q.cnt != GSP_FRAME_BITS) begin
        d.sh = sh_next;
        d.cnt = q.cnt + 5'h01;
        if (q.cnt == GSP_HDR_LAST && sh_next[15]) begin
          d.rd_active = 1'b1;
          d.rd_sh = rd_val;
        end
        if (q.cnt == GSP_FRAME_LAST && !sh_next[23]) begin
          if (wr_addr == GSP_OFS_PATH_CTRL) begin
            d.regs.manual_atten_enable = wr_data[GSP_POS_MAN_EN];
          end else if (wr_addr == GSP_OFS_ATT0_TX) begin
            d.regs.att0_tx = wr_data[GSP_CODE_W-1:0];
          end else if (wr_addr == GSP_OFS_ATT0_IDLE) begin
            d.regs.att0_idle = wr_data[GSP_CODE_W-1:0];
          end else if (wr_addr == GSP_OFS_MAN_FIRST) begin
            d.regs.man_first = wr_data[GSP_STEP_W-1:0];
          end else if (wr_addr == GSP_OFS_MAN_SECOND) begin
            d.regs.man_second = wr_data[GSP_STEP_W-1:0];
          end else if (wr_addr == GSP_OFS_LIN_CTRL) begin
            d.regs.first_amp_linearity_off_state1 = wr_data[GSP_POS_LIN_OFF1];
          end else if (wr_addr == GSP_OFS_TRIM1) begin
            d.regs.bias_trim_state1 = wr_data;
          end else if (wr_addr == GSP_OFS_TRIM2) begin
            d.regs.bias_trim_state2 = wr_data;
          end else if (wr_addr == GSP_OFS_TRIM3) begin
            d.regs.bias_trim_state3 = wr_data;
          end else if (wr_addr == GSP_OFS_ATT1) begin
            d.regs.atten_code_state1 = wr_data[GSP_CODE_W-1:0];
          end else if (wr_addr == GSP_OFS_ATT2) begin
            d.regs.atten_code_state2 = wr_data[GSP_CODE_W-1:0];
          end else if (wr_addr == GSP_OFS_ATT3) begin
            d.regs.atten_code_state3 = wr_data[GSP_CODE_W-1:0];
          end else if (wr_addr == GSP_OFS_LEVEL) begin
            d.regs.readback_level_select = wr_data[GSP_POS_LEVEL];
          end
        end
      end
      // Read data leaves on falling edges so the host can sample on rising ones.
      if (fall && q.rd_active) begin
        d.sdo = q.rd_sh[7];
        d.rd_sh = {q.rd_sh[6:0], 1'b0};
        d.sdo_oe = 1'b1;
      end
    end

    // Code selection from the synchronised gain state pins.
    code = q.regs.att0_idle;
    if (q.s2.tx_en) begin
      case (q.s2.sel)
        2'b01: code = q.regs.atten_code_state1;
        2'b10: code = q.regs.atten_code_state2;
        2'b11: code = q.regs.atten_code_state3;
        default: code = q.regs.att0_tx;
      endcase
    end
    // State 00 has no trim register in this bank, so it holds the reset trim.
    case (q.s2.sel)
      2'b01: trim = q.regs.bias_trim_state1;
      2'b10: trim = q.regs.bias_trim_state2;
      2'b11: trim = q.regs.bias_trim_state3;
      default: trim = GSP_RST_TRIM;
    endcase
    d.amp.second_amp_bias_trim = trim[7:GSP_POS_TRIM_SECOND];
    d.amp.first_amp_bias_trim = trim[GSP_POS_TRIM_SECOND-1:0];
    d.amp.first_amp_linearity_off = q.s2.tx_en && q.s2.sel == 2'b01 &&
                                    q.regs.first_amp_linearity_off_state1;

    if (q.s2.tx_en && q.regs.manual_atten_enable) begin
      d.amp.first_step_attenuator = q.regs.man_first;
      d.amp.second_step_attenuator = q.regs.man_second;
    end else if (code <= GSP_CODE_BOUNDARY) begin
      // Codes 31 and 32 both give the full second stage alone.
      d.amp.first_step_attenuator = 5'h00;
      d.amp.second_step_attenuator = (code == GSP_CODE_BOUNDARY) ? GSP_STEP_FULL :
                                     code[GSP_STEP_W-1:0];
    end else begin
      d.amp.first_step_attenuator = code[GSP_STEP_W-1:0];
      d.amp.second_step_attenuator = GSP_STEP_FULL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  assign spi_sdo_o = q.sdo;
  assign spi_sdo_oe_o = q.sdo_oe;
  assign readback_level_select_o = q.regs.readback_level_select;
  assign amp_ctrl_o = q.amp;

endmodule

// file: verification/gsp_preset_bank_properties.sv
// Concurrent checks on the port behaviour of the preset bank.
`timescale 1ns/1ps
module gsp_preset_bank_properties (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Serial register port.
  input wire logic spi_sclk_i,
  input wire logic spi_csb_n_i,
  input wire logic spi_sdi_i,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe_o,
  input wire logic readback_level_select_o,
  // Gain state pins and controls.
  input wire logic transmit_enable_pin_i,
  input wire logic [1:0] gain_state_select_pins_i,
  input wire gsp_pkg::gsp_amp_ctrl_type amp_ctrl_o
);
  import gsp_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // Five cycles cover the two sync flops and the output flop with margin.
  sequence tx_held_low;
    !transmit_enable_pin_i [*5];
  endsequence
  sequence sel_held_idle;
    (gain_state_select_pins_i == 2'b00) [*5];
  endsequence
  sequence pins_quiet;
    $stable(transmit_enable_pin_i) && $stable(gain_state_select_pins_i) && spi_csb_n_i;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // Manual mode may set the stages freely, but it only acts while transmit is high.
  stage_split_a: assert property (amp_ctrl_o.first_step_attenuator != 5'h00 &&
    amp_ctrl_o.second_step_attenuator != 5'h1f |-> $past(transmit_enable_pin_i, 3))
    else $error("first stage used below full second outside manual mode");
  linearity_cause_a: assert property (amp_ctrl_o.first_amp_linearity_off |->
    $past(transmit_enable_pin_i, 3) && $past(gain_state_select_pins_i, 3) == 2'b01)
    else $error("linearity off outside state 01");
  idle_preset_a: assert property (tx_held_low |->
    amp_ctrl_o.first_step_attenuator == 5'h1f && amp_ctrl_o.second_step_attenuator == 5'h1f)
    else $error("idle preset not applied");
  idle_trims_a: assert property (sel_held_idle |->
    amp_ctrl_o.first_amp_bias_trim == 4'h5 && amp_ctrl_o.second_amp_bias_trim == 4'h5)
    else $error("trims wrong for state 00");
  amp_stable_a: assert property (pins_quiet [*6] |=> $stable(amp_ctrl_o))
    else $error("controls moved with quiet pins");
  level_commit_a: assert property ($changed(readback_level_select_o) |->
    !spi_csb_n_i && spi_sclk_i) else $error("level changed outside a write commit");
  sdo_release_a: assert property (spi_csb_n_i [*5] |-> !spi_sdo_oe_o)
    else $error("read data driven while deselected");
  sdo_start_a: assert property ($rose(spi_sdo_oe_o) |-> !spi_csb_n_i && !spi_sclk_i)
    else $error("read drive began at wrong time");
  sdo_shift_a: assert property ($changed(spi_sdo_o) && spi_sdo_oe_o |-> !spi_sclk_i)
    else $error("read data moved while clock high");
endmodule
bind gsp_preset_bank gsp_preset_bank_properties u_props (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .spi_sclk_i(spi_sclk_i), .spi_csb_n_i(spi_csb_n_i), .spi_sdi_i(spi_sdi_i),
  .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o),
  .readback_level_select_o(readback_level_select_o),
  .transmit_enable_pin_i(transmit_enable_pin_i),
  .gain_state_select_pins_i(gain_state_select_pins_i), .amp_ctrl_o(amp_ctrl_o));

// file: verification/gsp_spi_host.sv
// Serial host model that runs register frames on the preset bank.
`timescale 1ns/1ps
module gsp_spi_host (
  // Bench clock, used only to place pin changes away from its rising edges.
  input wire logic clk_i,
  // Serial pins.
  output logic sclk_o,
  output logic csb_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // The clock stands low between frames; data flips on release so no stale bit is trusted.
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 8'h00;
    // With this start offset no later pin change lands on a rising clock edge.
    @(negedge clk_i);
    #0.25;
    csb_n_o = 1'b0;
    #62.5;
    for (int i = 23; i >= 0; i--) begin
      sdi_o = f[i];
      #62.5;
      sclk_o = 1'b1;
      if (i < 8) q[i] = sdo_oe_i ? sdo_i : ~sdo_i;
      #62.5;
      sclk_o = 1'b0;
    end
    #62.5;
    csb_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #62.5;
  endtask
endmodule

// file: verification/gsp_preset_bank_tb.sv
// Self-checking bench of the gain-state preset bank.
`timescale 1ns/1ps
module gsp_preset_bank_tb;
  import gsp_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic tx = 1'b0;
  logic [1:0] sel = 2'b00;
  logic sclk, csb_n, sdi, sdo, sdo_oe, level;
  gsp_amp_ctrl_type amp;
  logic [15:0] stg;
  assign stg = {6'h00, amp.first_step_attenuator, amp.second_step_attenuator};
  int fail_count = 0;
  int tests_run = 0;
  int seed = 98875;
  logic [7:0] q, v;
  logic [1:0] s;
  logic [5:0] c;
  logic [5:0] codes [8] = '{6'h00, 6'h1f, 6'h20, 6'h21, 6'h3f, 6'h01, 6'h1e, 6'h2a};
  always #2 clock_i = ~clock_i;
  gsp_preset_bank u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .spi_sclk_i(sclk),
    .spi_csb_n_i(csb_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
    .readback_level_select_o(level), .transmit_enable_pin_i(tx),
    .gain_state_select_pins_i(sel), .amp_ctrl_o(amp));
  gsp_spi_host u_host (.clk_i(clock_i), .sclk_o(sclk), .csb_n_o(csb_n), .sdi_o(sdi),
    .sdo_i(sdo), .sdo_oe_i(sdo_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Expected {first, second} stage steps; 31 and 32 share the boundary setting.
  function automatic logic [9:0] stages(input logic [5:0] code);
    if (code <= 6'h1f) return {5'h00, code[4:0]};
    if (code == 6'h20) return {5'h00, 5'h1f};
    return {5'(code - 6'h20), 5'h1f};
  endfunction
  task automatic pins(input logic t, input logic [1:0] st);
    @(negedge clock_i);
    tx = t;
    sel = st;
    repeat (8) @(negedge clock_i);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    u_host.xfer(1'b1, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clock_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    rd(GSP_OFS_TRIM1, 8'h55);
    rd(GSP_OFS_TRIM2, 8'h55);
    rd(GSP_OFS_TRIM3, 8'h55);
    rd(GSP_OFS_ATT1, 8'h18);
    rd(GSP_OFS_ATT2, 8'h30);
    rd(GSP_OFS_ATT3, 8'h3f);
    rd(GSP_OFS_LIN_CTRL, 8'h00);
    rd(GSP_OFS_LEVEL, 8'h00);
    rd(15'h0121, 8'h00);
    $display("reset values done");
    // Reserved bits are written high on purpose and must not read back.
    for (int k = 0; k < 14; k++) begin
      s = 2'(k % 3 + 1);
      c = (k < 8) ? codes[k] : 6'($random(seed));
      v = 8'($random(seed));
      wr(GSP_OFS_ATT1 + 15'(s - 2'd1), {2'b11, c});
      wr(GSP_OFS_TRIM1 + 15'(s - 2'd1), v);
      pins(1'b1, s);
      chk(stg, {6'h00, stages(c)});
      chk({8'h00, amp.second_amp_bias_trim, amp.first_amp_bias_trim}, {8'h00, v});
      rd(GSP_OFS_ATT1 + 15'(s - 2'd1), {2'b00, c});
      pins(1'b0, 2'b00);
      chk(stg, 16'h03ff);
    end
    $display("preset drive done");
    wr(GSP_OFS_LIN_CTRL, 8'hff);
    rd(GSP_OFS_LIN_CTRL, 8'h01);
    pins(1'b1, 2'b01);
    chk({15'h0000, amp.first_amp_linearity_off}, 16'h0001);
    pins(1'b1, 2'b10);
    chk({15'h0000, amp.first_amp_linearity_off}, 16'h0000);
    pins(1'b0, 2'b01);
    chk({15'h0000, amp.first_amp_linearity_off}, 16'h0000);
    $display("linearity done");
    // Transmit high on select 00 uses its own preset; manual mode then overrides it.
    c = 6'($random(seed));
    wr(GSP_OFS_ATT0_TX, {2'b11, c});
    rd(GSP_OFS_ATT0_TX, {2'b00, c});
    pins(1'b1, 2'b00);
    chk(stg, {6'h00, stages(c)});
    v = 8'($random(seed));
    wr(GSP_OFS_MAN_FIRST, {3'b111, v[4:0]});
    wr(GSP_OFS_MAN_SECOND, {3'b111, v[7:3]});
    wr(GSP_OFS_PATH_CTRL, 8'hff);
    rd(GSP_OFS_PATH_CTRL, 8'h80);
    rd(GSP_OFS_MAN_FIRST, {3'b000, v[4:0]});
    rd(GSP_OFS_MAN_SECOND, {3'b000, v[7:3]});
    chk(stg, {6'h00, v[4:0], v[7:3]});
    pins(1'b0, 2'b10);
    chk(stg, 16'h03ff);
    wr(GSP_OFS_PATH_CTRL, 8'h00);
    rd(GSP_OFS_PATH_CTRL, 8'h00);
    $display("manual done");
    wr(GSP_OFS_LEVEL, 8'hff);
    rd(GSP_OFS_LEVEL, 8'h01);
    chk({15'h0000, level}, 16'h0001);
    wr(GSP_OFS_LEVEL, 8'h00);
    chk({15'h0000, level}, 16'h0000);
    $display("level done");
    finish_test;
  end
  initial begin
    repeat (90000) @(posedge clock_i);
    fail_count++;
    finish_test;
  end
endmodule
